// >>> fiam_abort_capture.sv
// Purpose: sticky abort status and captured write address
// Assumes: abort_evt is a one-cycle pulse
// Notes:   a set in the clear cycle wins
`timescale 1ns/10ps
`include "fiam_consts.svh"
module fiam_abort_capture (
	input  wire logic clk_i,
	input  wire logic rst_i,
	fiam_if.cap       bus
);
	import fiam_pkg::*;
	logic [2:0] set; // hardware set strobes
	always_comb begin
		set = 3'h0;
		set[`FIAM_ST_ABORTED] = bus.abort_evt;
		set[`FIAM_ST_WRITE]   = bus.abort_evt && (bus.abort_op == OP_WRITE);
		// write or erase cut short: outcome cannot be known
		set[`FIAM_ST_UNKNOWN] = bus.abort_evt &&
			(bus.abort_op == OP_WRITE || bus.abort_op == OP_ERASE);
	end
	// sticky bits, set beats clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus.status <= 3'h0;
		end else begin
			bus.status <= (bus.status & ~bus.stat_clr) | set;
		end
	end
	// address of the location being written when a write is aborted
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus.abort_addr <= `FIAM_RST_ABORT_ADDR;
		end else if (set[`FIAM_ST_WRITE]) begin
			bus.abort_addr <= bus.abort_at;
		end
	end
endmodule

// >>> fiam_abort_gate.sv
// Purpose: gate interrupt lines with the abort masks during a flash operation
// Assumes: interrupt lines come from logic on clk_i
// Notes:   one abort pulse per operation
`timescale 1ns/10ps
module fiam_abort_gate (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic [31:0]       irq_i,
	input  wire logic              busy_i,
	input  wire fiam_pkg::fiam_op_e op_i,
	input  wire logic [31:0]       addr_i,
	fiam_if.gate                   bus
);
	import fiam_pkg::*;
	logic [31:0] hits;    // enabled and pending
	logic        done_q;  // abort already raised this operation
	logic [4:0]  vec;     // lowest hit index
	// a set mask bit lets its line abort, a clear one blocks it
	assign hits = irq_i & {bus.mask_second, bus.mask_first};
	// lowest vector wins when several fire together
	always_comb begin
		vec = 5'h0;
		for (int i = 31; i >= 0; i--) begin
			if (hits[i]) begin
				vec = 5'(i);
			end
		end
	end
	// pulse once, re-arm when the operation ends
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus.abort_evt <= 1'b0;
			done_q        <= 1'b0;
		end else begin
			bus.abort_evt <= busy_i && !done_q && (|hits);
			done_q        <= busy_i && (done_q || (|hits));
		end
	end
	// snapshot of what was hit
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus.abort_vec <= 5'h0;
			bus.abort_op  <= OP_WRITE;
			bus.abort_at  <= 32'h0000_0000;
		end else if (busy_i && !done_q && (|hits)) begin
			bus.abort_vec <= vec;
			bus.abort_op  <= op_i;
			bus.abort_at  <= addr_i;
		end
	end
endmodule

// >>> fiam_assertions.sv
// Purpose: concurrent checks on the flash abort mask top ports
// Assumes: one clock, synchronous active-high reset
// Notes:   mask shadows follow acknowledged bus writes
`timescale 1ns/10ps
`include "fiam_consts.svh"
module fiam_assertions
	import fiam_pkg::*;
#(
	parameter bit HAS_FIRST_CONVERTER = 1'b1 // low: first converter bit reserved
) (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        flash_busy_i,
	input wire fiam_op_e    flash_op_i,
	input wire logic        abort_o,
	input wire logic [4:0]  abort_vector_o,
	input wire logic        outcome_unknown_o
);
	// ----------------------------------------
	// mask shadows
	// ----------------------------------------
	logic [15:0] m0_q;   // first mask as software left it
	logic [15:0] m1_q;   // second mask
	logic [31:0] both;   // both masks as one vector set
	logic [15:0] lane;   // byte lanes of the write
	logic [15:0] wmask0; // writable bits of the first mask
	logic        wr_ack; // write completing at this edge
	logic        hit0;   // first mask addressed
	logic        hit1;   // second mask addressed
	logic        hit_st; // status addressed
	assign lane   = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wmask0 = HAS_FIRST_CONVERTER ? 16'hFBFF : 16'hDBFF;
	assign wr_ack = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
	assign hit0   = {wb_adr_i[31:2], 2'b00} == `FIAM_ADR_MASK_FIRST;
	assign hit1   = {wb_adr_i[31:2], 2'b00} == `FIAM_ADR_MASK_SECOND;
	assign hit_st = {wb_adr_i[31:2], 2'b00} == `FIAM_ADR_STATUS;
	assign both   = {m1_q, m0_q};
	// shadow moves only at the ack edge, as the master sees it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			m0_q <= 16'h0000;
			m1_q <= 16'h0000;
		end else if (wr_ack && hit0) begin
			m0_q <= (m0_q & ~(lane & wmask0)) | (wb_dat_i[15:0] & lane & wmask0);
		end else if (wr_ack && hit1) begin
			m1_q <= (m1_q & ~lane) | (wb_dat_i[15:0] & lane);
		end
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered next cycle");
	a_read_first: assert property (
		wb_ack_o && !wb_we_i && hit0 |-> wb_dat_o == {16'h0000, m0_q})
		else $error("first mask read mismatch");
	a_read_second: assert property (
		wb_ack_o && !wb_we_i && hit1 |-> wb_dat_o == {16'h0000, m1_q})
		else $error("second mask read mismatch");
	a_abort_enabled: assert property (
		abort_o |-> |($past(both) & (32'h0000_0001 << abort_vector_o)))
		else $error("abort from a masked vector");
	a_abort_busy: assert property (abort_o |-> $past(flash_busy_i))
		else $error("abort without a flash operation");
	a_abort_single: assert property (abort_o |=> !abort_o)
		else $error("abort pulse too long");
	a_unknown_set: assert property (
		abort_o && ($past(flash_op_i) inside {OP_WRITE, OP_ERASE}) |=> outcome_unknown_o)
		else $error("write or erase abort left outcome known");
	a_unknown_sticky: assert property (
		outcome_unknown_o && !(wr_ack && hit_st && wb_sel_i[0] && wb_dat_i[2])
		|=> outcome_unknown_o)
		else $error("unknown outcome dropped without clear");
endmodule
bind fiam_top fiam_assertions #(.HAS_FIRST_CONVERTER(HAS_FIRST_CONVERTER)) fiam_assertions_inst (
	.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
	.wb_dat_o, .wb_ack_o, .flash_busy_i, .flash_op_i, .abort_o, .abort_vector_o,
	.outcome_unknown_o);

// >>> fiam_consts.svh
// Purpose: addresses, reset values and bit positions of the flash abort mask block
// Assumes: 32-bit byte addresses on the register bus
// Notes:   definitions only
`ifndef FIAM_CONSTS_SVH
`define FIAM_CONSTS_SVH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define FIAM_ADR_MASK_FIRST  32'h4000_2878
`define FIAM_ADR_MASK_SECOND 32'h4000_287C
`define FIAM_ADR_STATUS      32'h4000_2890
`define FIAM_ADR_ABORT_ADDR  32'h4000_2894
// ----------------------------------------
// reset values
// ----------------------------------------
`define FIAM_RST_MASK        16'h0000
`define FIAM_RST_ABORT_ADDR  32'h0002_0800
// ----------------------------------------
// first mask register bit positions
// ----------------------------------------
`define FIAM_B0_FAST_FILTER  15
`define FIAM_B0_SECOND_CONV  14
`define FIAM_B0_FIRST_CONV   13
`define FIAM_B0_TIMER_ONE    12
`define FIAM_B0_TIMER_ZERO   11
`define FIAM_B0_RESERVED     10
`define FIAM_B0_WATCHDOG     9
`define FIAM_B0_EXT_LOW      1
`define FIAM_B0_WAKEUP       0
// ----------------------------------------
// second mask register bit positions
// ----------------------------------------
`define FIAM_B1_DAC_DMA      15
`define FIAM_B1_I2C_MASTER_IRQ_RX_DMA  14
`define FIAM_B1_I2C_MASTER_IRQ_TX_DMA  13
`define FIAM_B1_I2C_SLAVE_IRQ_RX_DMA  12
`define FIAM_B1_I2C_SLAVE_IRQ_TX_DMA  11
`define FIAM_B1_UART_RX_DMA  10
`define FIAM_B1_UART_TX_DMA  9
`define FIAM_B1_SECOND_SERIAL_PORT_IRQ_RX_DMA  8
`define FIAM_B1_SECOND_SERIAL_PORT_IRQ_TX_DMA  7
`define FIAM_B1_DMA_FAULT    6
`define FIAM_B1_I2C_MASTER_IRQ         5
`define FIAM_B1_I2C_SLAVE_IRQ         4
`define FIAM_B1_SECOND_SERIAL_PORT_IRQ         3
`define FIAM_B1_FIRST_SERIAL_PORT_IRQ         2
`define FIAM_B1_UART         1
`define FIAM_B1_FLASH        0
// ----------------------------------------
// status register bit positions
// ----------------------------------------
`define FIAM_ST_ABORTED      0
`define FIAM_ST_WRITE        1
`define FIAM_ST_UNKNOWN      2
`endif

// >>> fiam_if.sv
// Purpose: carrier between register file, abort gate and capture logic
// Assumes: single clock domain
// Notes:   no clocking block
`timescale 1ns/10ps
interface fiam_if;
	logic [15:0]      mask_first;   // vectors 0..15
	logic [15:0]      mask_second;  // vectors 16..31
	logic [2:0]       stat_clr;     // write-one-clear strobes
	logic             abort_evt;    // one-cycle abort pulse
	logic [4:0]       abort_vec;    // vector that caused it
	fiam_pkg::fiam_op_e abort_op;   // operation that was hit
	logic [31:0]      abort_at;     // address at the abort
	logic [2:0]       status;       // sticky status bits
	logic [31:0]      abort_addr;   // captured write address
	modport regs (output mask_first, mask_second, stat_clr, input status, abort_addr);
	modport gate (input mask_first, mask_second, output abort_evt, abort_vec, abort_op, abort_at);
	modport cap  (input abort_evt, abort_op, abort_at, stat_clr, output status, abort_addr);
endinterface

// >>> fiam_irq_sources.sv
// Purpose: on-chip interrupt sources facing the abort gate
// Assumes: sources run on the system clock
// Notes:   level interrupts, one register stage like a real peripheral
`timescale 1ns/10ps
module fiam_irq_sources (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [31:0] raise_i, // bit n raises vector n
	output logic      [31:0] lines_o  // interrupt levels by vector
);
	// ----------------------------------------
	// source flops
	// ----------------------------------------
	// levels move one edge after the request, never combinationally
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lines_o <= 32'h0000_0000;
		end else begin
			lines_o <= raise_i;
		end
	end
endmodule

// >>> fiam_pkg.sv
// Purpose: shared types and helpers of the flash abort mask block
// Assumes: nothing beyond the constants header
// Notes:   decoding used by more than one process lives here
package fiam_pkg;
	// kind of flash operation in progress
	typedef enum logic [1:0] {OP_WRITE, OP_ERASE, OP_SIGN, OP_VERIFY} fiam_op_e;
	// bus slave phases
	typedef enum logic {BUS_IDLE, BUS_ACK} fiam_bus_e;
	typedef logic [15:0] fiam_word_t;
	// word address match, byte lanes ignored
	function automatic logic fiam_hit(input logic [31:0] adr, input logic [31:0] base);
		fiam_hit = (adr[31:2] == base[31:2]);
	endfunction
	// byte-lane merge of a 16-bit register, only writable bits change
	function automatic fiam_word_t fiam_merge(input fiam_word_t old, input fiam_word_t wdat,
			input logic [1:0] sel, input fiam_word_t wr);
		fiam_word_t lane;
		lane = {{8{sel[1]}}, {8{sel[0]}}} & wr;
		fiam_merge = (old & ~lane) | (wdat & lane);
	endfunction
endpackage

// >>> fiam_top.sv
// Purpose: flash abort mask registers with classic Wishbone access
// Assumes: all interrupt and flash inputs are on clk_i
// Notes:   16-bit registers sit in the low half of each word
//
// Chosen here: the Wishbone register port.
`timescale 1ns/10ps
`include "fiam_consts.svh"

module fiam_top #(
	parameter bit HAS_FIRST_CONVERTER = 1'b1 // variant without it: bit reserved
) (
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	// ----------------------------------------
	// classic wishbone slave
	// ----------------------------------------
	input  wire logic               wb_cyc_i,
	input  wire logic               wb_stb_i,
	input  wire logic               wb_we_i,
	input  wire logic [31:0]        wb_adr_i,
	input  wire logic [3:0]         wb_sel_i,
	input  wire logic [31:0]        wb_dat_i,
	output logic      [31:0]        wb_dat_o,
	output logic                    wb_ack_o,
	// ----------------------------------------
	// sources for vectors 0..15
	// ----------------------------------------
	input  wire logic               fast_filter_irq_i,
	input  wire logic               second_converter_irq_i,
	input  wire logic               first_converter_irq_i,
	input  wire logic               general_timer_one_irq_i,
	input  wire logic               general_timer_zero_irq_i,
	input  wire logic               watchdog_irq_i,
	input  wire logic [7:0]         external_line_irq_i,
	input  wire logic               wakeup_timer_irq_i,
	// ----------------------------------------
	// sources for vectors 16..31
	// ----------------------------------------
	input  wire logic               dac_output_channel_irq_i,
	input  wire logic               i2c_master_receive_channel_irq_i,
	input  wire logic               i2c_master_transmit_channel_irq_i,
	input  wire logic               i2c_slave_receive_channel_irq_i,
	input  wire logic               i2c_slave_transmit_channel_irq_i,
	input  wire logic               uart_receive_channel_irq_i,
	input  wire logic               uart_transmit_channel_irq_i,
	input  wire logic               second_serial_port_receive_channel_irq_i,
	input  wire logic               second_serial_port_transmit_channel_irq_i,
	input  wire logic               dma_fault_irq_i,
	input  wire logic               i2c_master_irq_i,
	input  wire logic               i2c_slave_irq_i,
	input  wire logic               second_serial_port_irq_i,
	input  wire logic               first_serial_port_irq_i,
	input  wire logic               uart_irq_i,
	input  wire logic               flash_controller_irq_i,
	// ----------------------------------------
	// flash sequencer side
	// ----------------------------------------
	input  wire logic               flash_busy_i,
	input  wire fiam_pkg::fiam_op_e flash_op_i,
	input  wire logic [31:0]        flash_addr_i,
	output logic                    abort_o,
	output logic      [4:0]         abort_vector_o,
	output logic                    outcome_unknown_o
);
	import fiam_pkg::*;

	// ----------------------------------------
	// writable bit maps
	// ----------------------------------------
	// reserved bit 10 never stores; first converter bit only on full variant
	localparam fiam_word_t RES_FIRST = 16'h0001 << `FIAM_B0_RESERVED;
	localparam fiam_word_t CONV_BIT  = 16'h0001 << `FIAM_B0_FIRST_CONV;
	localparam fiam_word_t WR_FIRST  = 16'hFFFF & ~RES_FIRST &
		~(HAS_FIRST_CONVERTER ? 16'h0000 : CONV_BIT);
	// every bit of the second mask is a live enable
	localparam fiam_word_t WR_SECOND = 16'hFFFF;

	// ----------------------------------------
	// state
	// ----------------------------------------
	fiam_bus_e   bus_q;          // slave phase
	logic        we_q;           // latched direction
	logic [31:0] adr_q;          // latched address
	logic [3:0]  sel_q;          // latched lanes
	logic [31:0] wdat_q;         // latched write data
	fiam_word_t  mask_first_q;   // vectors 0..15
	fiam_word_t  mask_second_q;  // vectors 16..31
	logic [31:0] irq_vec;        // interrupt lines in vector order
	logic        take;           // new request this cycle
	logic        commit;         // write lands this edge
	logic [31:0] rdata;          // read mux

	fiam_if link ();

	// ----------------------------------------
	// vector ordering of sources
	// ----------------------------------------
	// each line sits at the bit of its mask enable, so the gate
	// only needs a plain and of lines with masks
	always_comb begin
		irq_vec = 32'h0000_0000;
		// vectors 0..15 -> first mask
		irq_vec[`FIAM_B0_FAST_FILTER] = fast_filter_irq_i;
		irq_vec[`FIAM_B0_SECOND_CONV] = second_converter_irq_i;
		irq_vec[`FIAM_B0_FIRST_CONV]  = HAS_FIRST_CONVERTER &&
			first_converter_irq_i;
		irq_vec[`FIAM_B0_TIMER_ONE]   = general_timer_one_irq_i;
		irq_vec[`FIAM_B0_TIMER_ZERO]  = general_timer_zero_irq_i;
		irq_vec[`FIAM_B0_WATCHDOG]    = watchdog_irq_i;
		// external lines 0..7 in bits 1..8, so line two is bit 3
		irq_vec[`FIAM_B0_EXT_LOW +: 8] = external_line_irq_i;
		irq_vec[`FIAM_B0_WAKEUP]      = wakeup_timer_irq_i;
		// vectors 16..31 -> second mask
		irq_vec[16 + `FIAM_B1_DAC_DMA]     = dac_output_channel_irq_i;
		irq_vec[16 + `FIAM_B1_I2C_MASTER_IRQ_RX_DMA] = i2c_master_receive_channel_irq_i;
		irq_vec[16 + `FIAM_B1_I2C_MASTER_IRQ_TX_DMA] = i2c_master_transmit_channel_irq_i;
		irq_vec[16 + `FIAM_B1_I2C_SLAVE_IRQ_RX_DMA] = i2c_slave_receive_channel_irq_i;
		irq_vec[16 + `FIAM_B1_I2C_SLAVE_IRQ_TX_DMA] = i2c_slave_transmit_channel_irq_i;
		irq_vec[16 + `FIAM_B1_UART_RX_DMA] = uart_receive_channel_irq_i;
		irq_vec[16 + `FIAM_B1_UART_TX_DMA] = uart_transmit_channel_irq_i;
		irq_vec[16 + `FIAM_B1_SECOND_SERIAL_PORT_IRQ_RX_DMA] = second_serial_port_receive_channel_irq_i;
		irq_vec[16 + `FIAM_B1_SECOND_SERIAL_PORT_IRQ_TX_DMA] = second_serial_port_transmit_channel_irq_i;
		irq_vec[16 + `FIAM_B1_DMA_FAULT]   = dma_fault_irq_i;
		irq_vec[16 + `FIAM_B1_I2C_MASTER_IRQ]        = i2c_master_irq_i;
		irq_vec[16 + `FIAM_B1_I2C_SLAVE_IRQ]        = i2c_slave_irq_i;
		irq_vec[16 + `FIAM_B1_SECOND_SERIAL_PORT_IRQ]        = second_serial_port_irq_i;
		irq_vec[16 + `FIAM_B1_FIRST_SERIAL_PORT_IRQ]        = first_serial_port_irq_i;
		irq_vec[16 + `FIAM_B1_UART]        = uart_irq_i;
		irq_vec[16 + `FIAM_B1_FLASH]       = flash_controller_irq_i;
	end

	// ----------------------------------------
	// wishbone slave phase
	// ----------------------------------------
	// a request is taken in idle, acked one cycle later, and the
	// write lands on that ack edge, when the master samples ack
	assign take   = (bus_q == BUS_IDLE) && wb_cyc_i && wb_stb_i;
	assign commit = (bus_q == BUS_ACK) && we_q;

	// phase machine, ack for exactly one cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_q    <= BUS_IDLE;
			wb_ack_o <= 1'b0;
		end else begin
			unique case (bus_q)
				BUS_IDLE: begin
					// wait for cyc and stb together
					if (take) begin
						bus_q    <= BUS_ACK;
						wb_ack_o <= 1'b1;
					end
				end
				BUS_ACK: begin
					// ack drops in the cycle after it was given
					bus_q    <= BUS_IDLE;
					wb_ack_o <= 1'b0;
				end
			endcase
		end
	end

	// request latch, held so the commit edge sees a stable copy
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			we_q   <= 1'b0;
			adr_q  <= 32'h0000_0000;
			sel_q  <= 4'h0;
			wdat_q <= 32'h0000_0000;
		end else if (take) begin
			we_q   <= wb_we_i;
			adr_q  <= wb_adr_i;
			sel_q  <= wb_sel_i;
			wdat_q <= wb_dat_i;
		end
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	// unmapped addresses read zero and still ack
	always_comb begin
		rdata = 32'h0000_0000;
		if (fiam_hit(wb_adr_i, `FIAM_ADR_MASK_FIRST)) begin
			rdata[15:0] = mask_first_q;
		end else if (fiam_hit(wb_adr_i, `FIAM_ADR_MASK_SECOND)) begin
			rdata[15:0] = mask_second_q;
		end else if (fiam_hit(wb_adr_i, `FIAM_ADR_STATUS)) begin
			rdata[2:0] = link.status;
		end else if (fiam_hit(wb_adr_i, `FIAM_ADR_ABORT_ADDR)) begin
			rdata = link.abort_addr;
		end
	end

	// read data caught at the taking edge, held through the ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (take) begin
			wb_dat_o <= wb_we_i ? 32'h0000_0000 : rdata;
		end
	end

	// ----------------------------------------
	// mask registers
	// ----------------------------------------
	// first mask: vectors 0..15, zero after reset so nothing aborts
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_first_q <= `FIAM_RST_MASK;
		end else if (commit && fiam_hit(adr_q, `FIAM_ADR_MASK_FIRST)) begin
			// 0x0008 here leaves external line two as the sole source
			mask_first_q <= fiam_merge(mask_first_q, wdat_q[15:0],
				sel_q[1:0], WR_FIRST);
		end
	end

	// second mask: vectors 16..31
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_second_q <= `FIAM_RST_MASK;
		end else if (commit && fiam_hit(adr_q, `FIAM_ADR_MASK_SECOND)) begin
			mask_second_q <= fiam_merge(mask_second_q, wdat_q[15:0],
				sel_q[1:0], WR_SECOND);
		end
	end

	// ----------------------------------------
	// status clear strobes
	// ----------------------------------------
	// write one to clear, only on the commit edge, low lane only
	always_comb begin
		link.stat_clr = 3'h0;
		if (commit && sel_q[0] && fiam_hit(adr_q, `FIAM_ADR_STATUS)) begin
			link.stat_clr = wdat_q[2:0];
		end
	end

	assign link.mask_first  = mask_first_q;
	assign link.mask_second = mask_second_q;

	// ----------------------------------------
	// abort gate and capture
	// ----------------------------------------
	// the gate fires a single pulse per operation; a second source
	// during the same operation is ignored since the flash is stopped
	fiam_abort_gate u_gate (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.irq_i  (irq_vec),
		.busy_i (flash_busy_i),
		.op_i   (flash_op_i),
		.addr_i (flash_addr_i),
		.bus    (link.gate)
	);

	// sticky status and abort address
	fiam_abort_capture u_cap (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.bus   (link.cap)
	);

	// ----------------------------------------
	// outputs, all straight from flops
	// ----------------------------------------
	assign abort_o           = link.abort_evt;
	assign abort_vector_o    = link.abort_vec;
	assign outcome_unknown_o = link.status[`FIAM_ST_UNKNOWN];
endmodule

// >>> test_flash_irq_abort_mask.sv
// Purpose: register and abort checks of the flash abort mask block
// Assumes: bus answers with one ack, aborts within a few cycles
// Notes:   expectations come from the bit map, not the design
`timescale 1ns/10ps
`include "fiam_consts.svh"
`define CHK(w, e, a) check(w, 32'(e), 32'(a))
module test_flash_irq_abort_mask;
	import fiam_pkg::*;
	logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic [31:0] wb_adr_i = 0, wb_dat_i = 0, wb_dat_o, flash_addr_i = 0, raise = 0, ln;
	logic [3:0]  wb_sel_i = 0;
	logic        wb_ack_o, flash_busy_i = 0, abort_o, outcome_unknown_o;
	logic [4:0]  abort_vector_o;
	fiam_op_e    flash_op_i = OP_WRITE;
	logic [31:0] rd, n, mk, lv; // scratch
	int          fail_count = 0, checked = 0;
	always #5 clk_i = ~clk_i;
	fiam_irq_sources fiam_irq_sources_inst (.clk_i(clk_i), .rst_i(rst_i), .raise_i(raise),
		.lines_o(ln));
	fiam_top #(.HAS_FIRST_CONVERTER(1'b1)) fiam_top_inst (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.wakeup_timer_irq_i(ln[0]), .external_line_irq_i(ln[8:1]), .watchdog_irq_i(ln[9]),
		.general_timer_zero_irq_i(ln[11]), .general_timer_one_irq_i(ln[12]),
		.first_converter_irq_i(ln[13]), .second_converter_irq_i(ln[14]),
		.fast_filter_irq_i(ln[15]), .flash_controller_irq_i(ln[16]), .uart_irq_i(ln[17]),
		.first_serial_port_irq_i(ln[18]), .second_serial_port_irq_i(ln[19]),
		.i2c_slave_irq_i(ln[20]), .i2c_master_irq_i(ln[21]), .dma_fault_irq_i(ln[22]),
		.second_serial_port_transmit_channel_irq_i(ln[23]),
		.second_serial_port_receive_channel_irq_i(ln[24]),
		.uart_transmit_channel_irq_i(ln[25]), .uart_receive_channel_irq_i(ln[26]),
		.i2c_slave_transmit_channel_irq_i(ln[27]), .i2c_slave_receive_channel_irq_i(ln[28]),
		.i2c_master_transmit_channel_irq_i(ln[29]),
		.i2c_master_receive_channel_irq_i(ln[30]), .dac_output_channel_irq_i(ln[31]),
		.flash_busy_i(flash_busy_i), .flash_op_i(flash_op_i), .flash_addr_i(flash_addr_i),
		.abort_o(abort_o), .abort_vector_o(abort_vector_o),
		.outcome_unknown_o(outcome_unknown_o));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	// counts every comparison, reports a mismatch at once
	task automatic check(input string w, input logic [31:0] e, input logic [31:0] a);
		checked++;
		if (a !== e) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", w, e, a);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// one classic cycle; entered right after an edge, leaves one idle cycle
	task automatic bus(input logic we, input logic [31:0] a, input logic [31:0] d,
			input logic [3:0] s);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= s;
		@(posedge clk_i iff wb_ack_o === 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rdchk(input string w, input logic [31:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000, 4'hF);
		`CHK(w, e, rd);
	endtask
	// run one flash operation with given lines raised; n counts abort pulses
	task automatic run_op(input fiam_op_e op, input logic [31:0] l, input logic b);
		raise        <= l;
		flash_busy_i <= b;
		flash_op_i   <= op;
		flash_addr_i <= 32'h0001_2340 + 32'(op);
		n = 0;
		repeat (5) begin
			@(posedge clk_i);
			if (abort_o === 1'b1)
				n++;
		end
		raise        <= 32'h0000_0000;
		flash_busy_i <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask
	// ----------------------------------------
	// watchdog and sequence
	// ----------------------------------------
	initial begin
		repeat (5000) @(posedge clk_i);
		fail_count++;
		end_of_test;
	end
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rdchk("mask first", `FIAM_ADR_MASK_FIRST, 32'h0000_0000);
		rdchk("mask second", `FIAM_ADR_MASK_SECOND, 32'h0000_0000);
		rdchk("abort address", `FIAM_ADR_ABORT_ADDR, `FIAM_RST_ABORT_ADDR);
		rdchk("unmapped", 32'h4000_2884, 32'h0000_0000);
		bus(1'b1, `FIAM_ADR_MASK_FIRST, 32'hFFFF_FFFF, 4'hF);
		rdchk("first all ones", `FIAM_ADR_MASK_FIRST, 32'h0000_FBFF);
		bus(1'b1, `FIAM_ADR_MASK_SECOND, 32'hFFFF_FFFF, 4'hF);
		rdchk("second all ones", `FIAM_ADR_MASK_SECOND, 32'h0000_FFFF);
		bus(1'b1, `FIAM_ADR_MASK_FIRST, 32'h0000_0000, 4'h1);
		rdchk("first low lane", `FIAM_ADR_MASK_FIRST, 32'h0000_FB00);
		bus(1'b1, 32'h4000_2884, 32'h0000_0000, 4'hF);
		rdchk("unmapped write", `FIAM_ADR_MASK_FIRST, 32'h0000_FB00);
		// only external line two may abort
		bus(1'b1, `FIAM_ADR_MASK_FIRST, 32'h0000_0008, 4'hF);
		bus(1'b1, `FIAM_ADR_MASK_SECOND, 32'h0000_0000, 4'hF);
		run_op(OP_ERASE, 32'h0000_0008, 1'b1);
		`CHK("line two aborts", 1, n);
		`CHK("line two vector", 3, abort_vector_o);
		run_op(OP_ERASE, 32'h0000_0010, 1'b1);
		`CHK("line three blocked", 0, n);
		run_op(OP_ERASE, 32'h0000_0008, 1'b0);
		`CHK("idle no abort", 0, n);
		// each vector alone through its mask bit, then through its line
		for (int v = 0; v < 32; v++) begin
			for (int p = 0; p < 2; p++) begin
				mk = p ? 32'hFFFF_FFFF : 32'h1 << v;
				lv = p ? 32'h1 << v : 32'hFFFF_FFFF;
				bus(1'b1, `FIAM_ADR_MASK_FIRST, {16'h0000, mk[15:0]}, 4'hF);
				bus(1'b1, `FIAM_ADR_MASK_SECOND, {16'h0000, mk[31:16]}, 4'hF);
				run_op(OP_SIGN, lv, 1'b1);
				`CHK("abort count", v != 10, n);
				if (v != 10)
					`CHK("abort vector", v, abort_vector_o);
			end
		end
		// every operation kind, status and captured write address
		bus(1'b1, `FIAM_ADR_STATUS, 32'h0000_0007, 4'h1);
		bus(1'b1, `FIAM_ADR_MASK_FIRST, 32'h0000_0001, 4'hF);
		bus(1'b1, `FIAM_ADR_MASK_SECOND, 32'h0000_0000, 4'hF);
		for (int k = 0; k < 4; k++) begin
			run_op(fiam_op_e'(k), 32'h0000_0001, 1'b1);
			rdchk("status", `FIAM_ADR_STATUS, {29'h0, k < 2, k == 0, 1'b1});
			`CHK("unknown pin", k < 2, outcome_unknown_o);
			rdchk("captured address", `FIAM_ADR_ABORT_ADDR, 32'h0001_2340);
			bus(1'b1, `FIAM_ADR_STATUS, 32'h0000_0007, 4'h1);
			rdchk("status cleared", `FIAM_ADR_STATUS, 32'h0000_0000);
		end
		end_of_test;
	end
endmodule
